/* design/conv_ctrl_defs.vh */
// shared constants for the conversion control block; its sample fifo uses none of them
// assumes inclusion by bare name from files under design/
`ifndef CONV_CTRL_DEFS_VH
`define CONV_CTRL_DEFS_VH

// opcodes: start/stop decoded on 7 bits, reset on the whole byte
`define OP_START_7        7'h04
`define OP_STOP_7         7'h05
`define OP_RESET          8'h06

// register addresses as seen on the write strobe port
`define ADDR_RATE_CHAIN   5'h01
`define ADDR_CONFIG_FOURTH 5'h17
`define ADDR_RESPIRATION_CONTROL_REG         5'h1a

// field positions
`define RATE_LSB          0
`define RATE_MSB          2
`define LOWPOWER_BIT      4
`define CLKOUT_EN_BIT     5
`define CHAIN_EN_BIT      6
`define SINGLE_SHOT_BIT   3

// reset values
`define RATE_CHAIN_RESET  8'h06
`define RESPIRATION_CONTROL_REG_RESET        8'h00
`define CONFIG_FOURTH_RESET 8'h00

// timing, in master clock periods; MCLK_DIV is clk periods per master clock
`define INIT_MCLK         5'd18
`define UPDATE_MCLK       16'd4
`define SETTLE_STEP       16'd288
`define SETTLE_OFFSET     16'd8
`define MCLK_DIV          98

// frame layout
`define WORD_BITS         5'd24
`define LAST_CHANNEL      4'd8
`define PAST_FRAME        4'd9

`endif

/* design/sample_fifo.v */
// sample fifo: memory plus one registered output word
// assumes writer and reader on the same clock
`timescale 1ns/1ps

module sample_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output reg              inReady,
  output reg  [WIDTH-1:0] outData,
  output reg              outValid,
  input  wire             outReady
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wrPtr_q;
  reg  [AW-1:0]    rdPtr_q;
  reg  [AW:0]      cnt_q;
  wire             wrEn   = inValid & inReady;
  wire             loadEn = (cnt_q != {(AW+1){1'b0}}) & (~outValid | outReady);
  wire [AW:0]      cnt_d  = cnt_q + {{AW{1'b0}}, wrEn} - {{AW{1'b0}}, loadEn};

  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q  <= {AW{1'b0}};
      rdPtr_q  <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      inReady  <= 1'b0;
      outValid <= 1'b0;
      outData  <= {WIDTH{1'b0}};
    end else begin
      cnt_q   <= cnt_d;
      // registered ready: stalls the source honestly when memory is full
      inReady <= (cnt_d < DEPTH);
      if (wrEn) begin
        wrPtr_q <= (wrPtr_q == DEPTH - 1) ? {AW{1'b0}} : wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (loadEn) begin
        outData  <= mem[rdPtr_q];
        outValid <= 1'b1;
        rdPtr_q  <= (rdPtr_q == DEPTH - 1) ? {AW{1'b0}} : rdPtr_q + {{(AW-1){1'b0}}, 1'b1};
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end

endmodule

/* design/conv_ctrl.v */
// conversion start/stop, reset, settling and chained readout control
// assumes serial pins, start and reset pins are asynchronous to clk;
// register writes, samples and status word arrive on clk
`timescale 1ns/1ps
`include "conv_ctrl_defs.vh"

module conv_ctrl #(
  parameter        MCLK_DIV      = `MCLK_DIV,
  parameter [15:0] SETTLE_STEP   = `SETTLE_STEP,
  parameter [15:0] SETTLE_OFFSET = `SETTLE_OFFSET,
  parameter        FIFO_DEPTH    = 8
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        resetPinN,
  input  wire        startPin,
  input  wire        sclk,
  input  wire        csN,
  input  wire        din,
  input  wire        daisyIn,
  input  wire        clockSourcePin,
  input  wire        regWrite,
  input  wire [4:0]  regAddr,
  input  wire [7:0]  regData,
  input  wire [23:0] sampleData,
  input  wire        sampleValid,
  input  wire [23:0] statusWord,
  output wire        sampleReady,
  output reg         resultReadyN,
  output reg         dout,
  output reg         doutOe,
  output reg         masterClkOut,
  output reg         masterClkOe,
  output reg         filterReset,
  output reg  [7:0]  rateChainConfigReg,
  output reg  [7:0]  respirationControlReg,
  output reg  [7:0]  configRegFourth,
  output reg         converting
);

  localparam [2:0] ST_INIT = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  // two-flop synchronisers, plus history flops on start and serial clock for edge finding
  reg [1:0] syncRst_q, syncStart_q, syncSclk_q, syncCs_q, syncDin_q, syncDaisy_q, syncSrc_q;
  reg       startOld_q;
  reg       sclkOld_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncRst_q   <= 2'b00;
      syncStart_q <= 2'b00;
      syncSclk_q  <= 2'b00;
      syncCs_q    <= 2'b11;
      syncDin_q   <= 2'b00;
      syncDaisy_q <= 2'b00;
      syncSrc_q   <= 2'b00;
      startOld_q  <= 1'b0;
      sclkOld_q   <= 1'b0;
    end else begin
      syncRst_q   <= {syncRst_q[0], resetPinN};
      syncStart_q <= {syncStart_q[0], startPin};
      syncSclk_q  <= {syncSclk_q[0], sclk};
      syncCs_q    <= {syncCs_q[0], csN};
      syncDin_q   <= {syncDin_q[0], din};
      syncDaisy_q <= {syncDaisy_q[0], daisyIn};
      syncSrc_q   <= {syncSrc_q[0], clockSourcePin};
      startOld_q  <= syncStart_q[1];
      sclkOld_q   <= syncSclk_q[1];
    end
  end

  wire startLvl  = syncStart_q[1];
  wire startRise = startLvl & ~startOld_q;
  wire startFall = ~startLvl & startOld_q;
  wire csActive  = ~syncCs_q[1];
  wire sclkRise  = syncSclk_q[1] & ~sclkOld_q & csActive;
  wire sclkFall  = ~syncSclk_q[1] & sclkOld_q & csActive;

  // master clock: one-cycle enable from a divider, level for the clock output
  reg  [7:0] divCnt_q;
  wire       mclkTick = (divCnt_q == MCLK_DIV - 1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q     <= 8'h00;
      masterClkOut <= 1'b0;
      masterClkOe  <= 1'b0;
    end else begin
      divCnt_q     <= mclkTick ? 8'h00 : divCnt_q + 8'h01;
      masterClkOut <= (divCnt_q < MCLK_DIV / 2);
      masterClkOe  <= syncSrc_q[1] & rateChainConfigReg[`CLKOUT_EN_BIT];
    end
  end

  // opcode shifter on serial falling edges; a raised chip select clears its bit count
  reg  [6:0] opShift_q;
  reg  [2:0] opCnt_q;
  wire [7:0] opByte   = {opShift_q, syncDin_q[1]};
  wire       opStart  = sclkFall & (opCnt_q == 3'd6) & (opByte[6:0] == `OP_START_7);
  wire       opStop   = sclkFall & (opCnt_q == 3'd6) & (opByte[6:0] == `OP_STOP_7);
  wire       opReset  = sclkFall & (opCnt_q == 3'd7) & (opByte == `OP_RESET);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opShift_q <= 7'h00;
      opCnt_q   <= 3'd0;
    end else if (!csActive) begin
      opCnt_q   <= 3'd0;
    end else if (sclkFall) begin
      opShift_q <= opByte[6:0];
      opCnt_q   <= opCnt_q + 3'd1;
    end
  end

  wire resetReq   = ~syncRst_q[1] | opReset;
  wire singleShot = configRegFourth[`SINGLE_SHOT_BIT];
  wire chainEn    = rateChainConfigReg[`CHAIN_EN_BIT];

  // settle count: step doubles per rate code up to 6 (7 runs as 6), low power shifts one more
  wire [2:0]  rateCode = rateChainConfigReg[`RATE_MSB:`RATE_LSB];
  wire [2:0]  rateEff  = (rateCode == 3'd7) ? 3'd6 : rateCode;
  wire [3:0]  shiftAmt = {1'b0, rateEff} + {3'b000, rateChainConfigReg[`LOWPOWER_BIT]};
  wire [23:0] settleW  = ({8'h00, SETTLE_STEP} << shiftAmt) + {8'h00, SETTLE_OFFSET};
  wire [15:0] settleN  = settleW[15:0];

  reg  [2:0]  state_q;
  reg  [4:0]  initCnt_q;
  reg  [15:0] convCnt_q;
  reg         stopPend_q;
  wire        convDone = (state_q == ST_CONV) & mclkTick & (convCnt_q == settleN - 16'd1);
  wire        startReq = startRise | opStart;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= ST_INIT;
      initCnt_q  <= 5'd0;
      convCnt_q  <= 16'd0;
      stopPend_q <= 1'b0;
      converting <= 1'b0;
    end else if (resetReq) begin
      state_q    <= ST_INIT;
      initCnt_q  <= 5'd0;
      stopPend_q <= 1'b0;
      converting <= 1'b0;
    end else begin
      case (state_q)
        ST_INIT: begin
          if (mclkTick) begin
            initCnt_q <= initCnt_q + 5'd1;
            if (initCnt_q == `INIT_MCLK - 5'd1) begin
              convCnt_q  <= 16'd0;
              state_q    <= startLvl ? ST_CONV : ST_IDLE;
              converting <= startLvl;
            end
          end
        end
        ST_IDLE: begin
          if (startReq) begin
            state_q    <= ST_CONV;
            convCnt_q  <= 16'd0;
            stopPend_q <= 1'b0;
            converting <= 1'b1;
          end
        end
        ST_CONV: begin
          // a start while running has no effect
          if (startFall | opStop) begin
            stopPend_q <= 1'b1;
          end
          if (convDone) begin
            convCnt_q <= 16'd0;
            if (singleShot | stopPend_q | startFall | opStop) begin
              state_q    <= ST_IDLE;
              stopPend_q <= 1'b0;
              converting <= 1'b0;
            end
          end else if (mclkTick) begin
            convCnt_q <= convCnt_q + 16'd1;
          end
        end
        default: begin
          state_q <= ST_INIT;
        end
      endcase
    end
  end

  // configuration registers; defaults reloaded throughout initialisation
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rateChainConfigReg    <= `RATE_CHAIN_RESET;
      respirationControlReg <= `RESPIRATION_CONTROL_REG_RESET;
      configRegFourth       <= `CONFIG_FOURTH_RESET;
      filterReset           <= 1'b0;
    end else if (resetReq | (state_q == ST_INIT)) begin
      rateChainConfigReg    <= `RATE_CHAIN_RESET;
      respirationControlReg <= `RESPIRATION_CONTROL_REG_RESET;
      configRegFourth       <= `CONFIG_FOURTH_RESET;
      filterReset           <= 1'b1;
    end else begin
      filterReset <= 1'b0;
      if (regWrite) begin
        if (regAddr == `ADDR_RATE_CHAIN) begin
          rateChainConfigReg <= regData;
          filterReset        <= (regData != rateChainConfigReg);
        end else if (regAddr == `ADDR_RESPIRATION_CONTROL_REG) begin
          respirationControlReg <= regData;
          filterReset           <= (regData != respirationControlReg);
        end else if (regAddr == `ADDR_CONFIG_FOURTH) begin
          configRegFourth <= regData;
        end
      end
    end
  end

  // data-ready: high on start, high again just before a repeat result
  wire convBegin  = ((state_q == ST_IDLE) & startReq & ~resetReq) |
                    ((state_q == ST_INIT) & mclkTick & (initCnt_q == `INIT_MCLK - 5'd1) &
                     startLvl & ~resetReq);
  wire preUpdate  = (state_q == ST_CONV) & mclkTick & (convCnt_q == settleN - `UPDATE_MCLK);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resultReadyN <= 1'b1;
    end else if (resetReq | (state_q == ST_INIT)) begin
      resultReadyN <= 1'b1;
    end else if (convDone) begin
      resultReadyN <= 1'b0;
    end else if (convBegin | preUpdate) begin
      resultReadyN <= 1'b1;
    end else if (sclkFall & ~resultReadyN & ~singleShot) begin
      resultReadyN <= 1'b1;
    end
    // single-shot keeps it low until the next start or a reset
  end

  // readout: status word, then channel words drained from the fifo
  wire [23:0] fifoData;
  wire        fifoValid;
  reg  [23:0] shift_q;
  reg  [4:0]  bitInWord_q;
  reg  [3:0]  wordIdx_q;
  reg         chainBit_q;
  wire        wordEnd  = sclkRise & (wordIdx_q < `PAST_FRAME) & (bitInWord_q == `WORD_BITS - 5'd1);
  wire        fifoPop  = wordEnd & ~convDone & (wordIdx_q < `LAST_CHANNEL) & fifoValid;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_q     <= 24'h000000;
      bitInWord_q <= 5'd0;
      wordIdx_q   <= `PAST_FRAME;
      chainBit_q  <= 1'b0;
      dout        <= 1'b0;
      doutOe      <= 1'b0;
    end else begin
      doutOe <= csActive;
      if (sclkRise) begin
        chainBit_q <= syncDaisy_q[1];
      end
      if (convDone) begin
        shift_q     <= statusWord;
        bitInWord_q <= 5'd0;
        wordIdx_q   <= 4'd0;
      end else if (sclkRise) begin
        if (wordIdx_q < `PAST_FRAME) begin
          dout <= shift_q[23];
          if (wordEnd) begin
            bitInWord_q <= 5'd0;
            wordIdx_q   <= wordIdx_q + 4'd1;
            // an empty fifo reads as a zero channel
            shift_q     <= fifoPop ? fifoData : 24'h000000;
          end else begin
            bitInWord_q <= bitInWord_q + 5'd1;
            shift_q     <= {shift_q[22:0], 1'b0};
          end
        end else begin
          // one-bit lag through chainBit_q is the extra clock between sets
          // no repeat of the own frame in either mode
          dout <= chainEn ? chainBit_q : 1'b0;
        end
      end
    end
  end

  sample_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .inData   (sampleData),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

endmodule

/* verif/conv_ctrl_monitor.sv */
// checker on the conversion control ports
// assumes bind into conv_ctrl, one clk domain
`timescale 1ns/1ps
module conv_ctrl_monitor #(
  parameter        MCLK_DIV      = 98,
  parameter [15:0] SETTLE_STEP   = 16'h0120,
  parameter [15:0] SETTLE_OFFSET = 16'h0008
) (
  input logic       clk,
  input logic       rstn,
  input logic       resetPinN,
  input logic       startPin,
  input logic       sclk,
  input logic       csN,
  input logic       clockSourcePin,
  input logic       regWrite,
  input logic [4:0] regAddr,
  input logic [7:0] regData,
  input logic       resultReadyN,
  input logic       doutOe,
  input logic       masterClkOe,
  input logic       filterReset,
  input logic [7:0] rateChainConfigReg,
  input logic [7:0] configRegFourth,
  input logic       converting
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic        convQ;
  logic        rdyQ;
  logic        first;
  int          cnt;
  int          initCnt;
  logic [31:0] settle;
  wire  [2:0]  rate = rateChainConfigReg[2:0];
  // rate code 7 runs as code 6
  assign settle = ((int'(SETTLE_STEP) << ((rate == 3'h7 ? 6 : rate) + rateChainConfigReg[4]))
                  + int'(SETTLE_OFFSET)) * MCLK_DIV;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {convQ, rdyQ, first} <= 3'b010;
      cnt <= 0;
      initCnt <= 0;
    end else begin
      convQ <= converting;
      rdyQ <= resultReadyN;
      cnt <= (converting && !convQ) ? 1 : cnt + 1;
      initCnt <= (filterReset && resetPinN) ? initCnt + 1 : 0;
      if (converting && !convQ)
        first <= 1'b1;
      else if (!resultReadyN && rdyQ)
        first <= 1'b0;
    end
  end
  a_ready_needs_conv: assert property ($fell(resultReadyN) |-> converting || $past(converting))
    else $error("ready fell while idle");
  a_first_delay: assert property ($fell(resultReadyN) && first |->
    cnt + MCLK_DIV + 4 >= settle && cnt <= settle + MCLK_DIV + 4)
    else $error("first result delay off");
  a_single_hold: assert property (configRegFourth[3] && !resultReadyN && !converting
    && !startPin && csN && resetPinN |=> !resultReadyN)
    else $error("single-shot ready rose");
  a_oe_released: assert property (csN [*4] |-> !doutOe)
    else $error("data out driven while deselected");
  a_clkout_gated: assert property (!clockSourcePin [*4] |-> !masterClkOe)
    else $error("clock out enabled without source pin");
  a_filter_pulse: assert property (regWrite && !filterReset && regAddr == 5'h01
    && regData != rateChainConfigReg |=> filterReset && rateChainConfigReg == $past(regData))
    else $error("changing write gave no filter reset");
  a_init_length: assert property ($fell(filterReset) && initCnt > 2 |->
    initCnt > 17 * MCLK_DIV && initCnt <= 19 * MCLK_DIV + 4)
    else $error("init length off");
  a_sclk_release: assert property (!configRegFourth[3] && !resultReadyN && $fell(sclk)
    |-> ##[1:6] resultReadyN)
    else $error("ready not released by serial clock");
endmodule

bind conv_ctrl conv_ctrl_monitor #(.MCLK_DIV(MCLK_DIV), .SETTLE_STEP(SETTLE_STEP),
  .SETTLE_OFFSET(SETTLE_OFFSET)) i_conv_ctrl_monitor (
  .clk                (clk),
  .rstn               (rstn),
  .resetPinN          (resetPinN),
  .startPin           (startPin),
  .sclk               (sclk),
  .csN                (csN),
  .clockSourcePin     (clockSourcePin),
  .regWrite           (regWrite),
  .regAddr            (regAddr),
  .regData            (regData),
  .resultReadyN       (resultReadyN),
  .doutOe             (doutOe),
  .masterClkOe        (masterClkOe),
  .filterReset        (filterReset),
  .rateChainConfigReg (rateChainConfigReg),
  .configRegFourth    (configRegFourth),
  .converting         (converting)
);

/* verif/host_link_model.sv */
// host side: serial clock, select, command data and chain input
// assumes clk is the bench clock; serial clock period 16 clk
`timescale 1ns/1ps
module host_link_model (
  input  wire  clk,
  input  wire  dout,
  output logic sclk,
  output logic csN,
  output logic din,
  output logic daisyIn
);
  initial {sclk, csN, din, daisyIn} = 4'b0100;
  task automatic half;
    repeat (8) @(negedge clk);
  endtask
  // opcodes go out whole; the bench keeps the start pin low meanwhile
  task automatic sendByte(input logic [7:0] b);
    // idle gap so a following transfer never lowers select in the same step
    half();
    csN = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      half();
      sclk = 1'b1;
      din = b[i];
      half();
      sclk = 1'b0;
    end
    half();
    half();
    csN = 1'b1;
    din = ~din;
  endtask
  // clocks past the frame bring the chain input through
  task automatic readFrame(input int n, input logic [255:0] pat, output logic [255:0] got);
    half();
    got = '0;
    din = 1'b0;
    csN = 1'b0;
    for (int k = 1; k <= n; k++) begin
      daisyIn = pat[k];
      half();
      sclk = 1'b1;
      half();
      got = {got[254:0], dout};
      sclk = 1'b0;
    end
    half();
    csN = 1'b1;
    daisyIn = ~daisyIn;
  endtask
endmodule

/* verif/test_conv_ctrl.sv */
// self-checking bench for the conversion control block
// assumes the host model drives the serial pins; fifo sits inside the block
`timescale 1ns/1ps
module test_conv_ctrl;
  localparam int DIV = 4;
  logic         clk = 1'b0;
  logic         rstn;
  logic         resetPinN;
  logic         startPin;
  logic         clockSourcePin;
  logic         regWrite;
  logic         sampleValid;
  logic [4:0]   regAddr;
  logic [7:0]   regData;
  logic [23:0]  sampleData;
  logic [23:0]  statusWord;
  wire          sclk, csN, din, daisyIn, sampleReady, resultReadyN, dout, doutOe;
  wire          masterClkOut, masterClkOe, filterReset, converting;
  wire  [7:0]   rateChainConfigReg, respirationControlReg, configRegFourth;
  integer       seed = 32'hc89a;
  int           errorCnt = 0;
  int           checkCount = 0;
  int           c;
  int           n;
  logic [255:0] pat;
  logic [255:0] got;
  logic [23:0]  wq[$];
  logic [23:0]  ew[8];
  logic         taken;
  logic         prev;

  always #2.5 clk = ~clk;

  conv_ctrl #(.MCLK_DIV(DIV), .SETTLE_STEP(16'h0008), .SETTLE_OFFSET(16'h0008),
    .FIFO_DEPTH(8)) i_conv_ctrl (
    .clk                   (clk),
    .rstn                  (rstn),
    .resetPinN             (resetPinN),
    .startPin              (startPin),
    .sclk                  (sclk),
    .csN                   (csN),
    .din                   (din),
    .daisyIn               (daisyIn),
    .clockSourcePin        (clockSourcePin),
    .regWrite              (regWrite),
    .regAddr               (regAddr),
    .regData               (regData),
    .sampleData            (sampleData),
    .sampleValid           (sampleValid),
    .statusWord            (statusWord),
    .sampleReady           (sampleReady),
    .resultReadyN          (resultReadyN),
    .dout                  (dout),
    .doutOe                (doutOe),
    .masterClkOut          (masterClkOut),
    .masterClkOe           (masterClkOe),
    .filterReset           (filterReset),
    .rateChainConfigReg    (rateChainConfigReg),
    .respirationControlReg (respirationControlReg),
    .configRegFourth       (configRegFourth),
    .converting            (converting)
  );
  host_link_model i_host_link_model (
    .clk     (clk),
    .dout    (dout),
    .sclk    (sclk),
    .csN     (csN),
    .din     (din),
    .daisyIn (daisyIn)
  );

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // sel 0 ready, 1 filter reset, 2 converting; c keeps adding up
  task automatic waitFor(input int sel, input logic lvl);
    int k;
    k = 0;
    while ((sel == 0 ? resultReadyN : sel == 1 ? filterReset : converting) !== lvl) begin
      @(negedge clk);
      c++;
      k++;
      if (k > 20000) begin
        check(k, 0);
        endOfTest();
      end
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    // a gap cycle keeps back-to-back writes from re-raising the strobe at once
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regData = d;
    @(negedge clk);
    regWrite = 1'b0;
  endtask
  function automatic int expSettle(input int r);
    return ((8 << ((r % 8 == 7 ? 6 : r % 8) + r / 8)) + 8) * DIV;
  endfunction
  task automatic frame(input logic [23:0] st);
    for (int i = 0; i < 8; i++) pat[i * 32 +: 32] = $random(seed);
    i_host_link_model.readFrame(218, pat, got);
    check(got[217:194], st);
    for (int i = 0; i < 8; i++) check(got[193 - 24 * i -: 24], ew[i]);
    check(got[1:0], {pat[216], pat[217]});
  endtask

  initial begin
    rstn = 1'b0;
    resetPinN = 1'b1;
    startPin = 1'b0;
    clockSourcePin = 1'b0;
    regWrite = 1'b0;
    sampleValid = 1'b0;
    regAddr = 5'($random(seed));
    regData = 8'($random(seed));
    sampleData = 24'($random(seed));
    statusWord = 24'($random(seed));
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    check({rateChainConfigReg, respirationControlReg, configRegFourth}, 24'h060000);
    startPin = 1'b1;
    repeat (60) @(negedge clk);
    check({filterReset, converting, resultReadyN}, 3'b101);
    waitFor(1, 1'b0);
    waitFor(2, 1'b1);
    startPin = 1'b0;
    waitFor(2, 1'b0);
    done("power up");
    wr(5'h01, 8'h00);
    check({filterReset, rateChainConfigReg}, 9'h100);
    wr(5'h01, 8'h00);
    check(filterReset, 1'b0);
    wr(5'h1a, 8'h05);
    check({filterReset, respirationControlReg}, 9'h105);
    wr(5'h02, 8'hff);
    check({rateChainConfigReg, respirationControlReg, configRegFourth}, 24'h000500);
    clockSourcePin = 1'b1;
    wr(5'h01, 8'h20);
    repeat (4) @(negedge clk);
    prev = masterClkOut;
    n = 0;
    repeat (4 * DIV) begin
      @(negedge clk);
      n += (masterClkOut !== prev);
      prev = masterClkOut;
    end
    check({masterClkOe, n > 1}, 2'b11);
    clockSourcePin = 1'b0;
    repeat (4) @(negedge clk);
    check(masterClkOe, 1'b0);
    done("registers");
    for (int r = 0; r < 16; r++) begin
      wr(5'h01, {3'b000, r[3], 1'b0, r[2:0]});
      c = 0;
      startPin = 1'b1;
      waitFor(0, 1'b1);
      waitFor(0, 1'b0);
      check(c + DIV >= expSettle(r) && c <= expSettle(r) + 2 * DIV + 8, 1'b1);
      startPin = 1'b0;
      waitFor(2, 1'b0);
    end
    done("settling");
    wr(5'h01, 8'h40);
    wr(5'h17, 8'h08);
    sampleValid = 1'b1;
    sampleData = 24'($random(seed));
    repeat (12) begin
      taken = sampleReady;
      @(negedge clk);
      if (taken === 1'b1) begin
        wq.push_back(sampleData);
        sampleData = 24'($random(seed));
      end
    end
    sampleValid = 1'b0;
    check(wq.size(), 9);
    for (int i = 0; i < 8; i++) ew[i] = wq[i];
    statusWord = 24'($random(seed));
    i_host_link_model.sendByte(8'h08);
    waitFor(0, 1'b0);
    repeat (8 * DIV) @(negedge clk);
    check({converting, resultReadyN}, 2'b00);
    frame(statusWord);
    check({resultReadyN, sampleReady}, 2'b01);
    repeat (4) @(negedge clk);
    check(doutOe, 1'b0);
    ew[0] = wq[8];
    for (int i = 1; i < 8; i++) ew[i] = 24'h000000;
    statusWord = 24'($random(seed));
    i_host_link_model.sendByte(8'h08);
    waitFor(0, 1'b0);
    frame(statusWord);
    done("single shot");
    wr(5'h01, 8'h03);
    wr(5'h17, 8'h00);
    i_host_link_model.sendByte(8'h0a);
    i_host_link_model.sendByte(8'h08);
    waitFor(0, 1'b0);
    i_host_link_model.sendByte(8'h0a);
    n = 0;
    prev = resultReadyN;
    repeat (1000) begin
      @(negedge clk);
      n += (prev && !resultReadyN);
      prev = resultReadyN;
    end
    check({n[3:0], converting}, 5'h02);
    done("stop");
    wr(5'h17, 8'h08);
    i_host_link_model.sendByte(8'h07);
    check({filterReset, configRegFourth}, 9'h008);
    i_host_link_model.sendByte(8'h06);
    check({filterReset, configRegFourth}, 9'h100);
    waitFor(1, 1'b0);
    wr(5'h01, 8'h00);
    resetPinN = 1'b0;
    repeat (8) @(negedge clk);
    resetPinN = 1'b1;
    check({filterReset, rateChainConfigReg}, 9'h106);
    waitFor(1, 1'b0);
    done("reset paths");
    endOfTest();
  end
endmodule
